// >>> mde_pkg.sv
// constants and types shared by the decode/execute core
package mde_pkg;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  localparam int unsigned OSC_PER_CYCLE = 4;
  typedef enum logic [3:0] {
    MDE_PH1 = 4'b0001,
    MDE_PH2 = 4'b0010,
    MDE_PH3 = 4'b0100,
    MDE_PH4 = 4'b1000
  } mde_phase_type;

  // ---------------------------------------------------------------
  // file map and reset values
  // ---------------------------------------------------------------
  localparam logic [6:0]  ADDR_TMR     = 7'h01;
  localparam logic [6:0]  ADDR_PCL     = 7'h02;
  localparam logic [6:0]  ADDR_STATUS  = 7'h03;
  localparam logic [6:0]  ADDR_PORT0   = 7'h05;
  localparam logic [6:0]  ADDR_PC_HIGH_HOLDING_LATCH  = 7'h0A;
  localparam int unsigned PORT_NUM     = 3;
  localparam int unsigned ST_C         = 0;
  localparam int unsigned ST_DC        = 1;
  localparam int unsigned ST_Z         = 2;
  localparam int unsigned ST_PD        = 3;
  localparam int unsigned ST_TO        = 4;
  localparam logic [7:0]  STATUS_RST   = 8'h18;
  localparam logic [12:0] PC_RST       = 13'h0000;
  localparam logic [4:0]  PC_HIGH_HOLDING_LATCH_RST   = 5'h00;
  localparam logic [7:0]  W_RST        = 8'h00;
  localparam logic [13:0] IR_NOP       = 14'h0000;

  // ---------------------------------------------------------------
  // opcode fields
  // ---------------------------------------------------------------
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT  = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT  = 2'h3;
  localparam logic [3:0] OPB_MOVWF = 4'h0;
  localparam logic [3:0] OPB_CLR   = 4'h1;
  localparam logic [3:0] OPB_SUB   = 4'h2;
  localparam logic [3:0] OPB_DEC   = 4'h3;
  localparam logic [3:0] OPB_IOR   = 4'h4;
  localparam logic [3:0] OPB_AND   = 4'h5;
  localparam logic [3:0] OPB_XOR   = 4'h6;
  localparam logic [3:0] OPB_ADD   = 4'h7;
  localparam logic [3:0] OPB_MOV   = 4'h8;
  localparam logic [3:0] OPB_COM   = 4'h9;
  localparam logic [3:0] OPB_INC   = 4'hA;
  localparam logic [3:0] OPB_DECSZ = 4'hB;
  localparam logic [3:0] OPB_RR    = 4'hC;
  localparam logic [3:0] OPB_RL    = 4'hD;
  localparam logic [3:0] OPB_SWAP  = 4'hE;
  localparam logic [3:0] OPB_INCSZ = 4'hF;
  localparam logic [7:0] CTL_RETURN = 8'h08;
  localparam logic [7:0] CTL_RETINT = 8'h09;
  localparam logic [7:0] CTL_STBY   = 8'h63;
  localparam logic [7:0] CTL_WDCLR  = 8'h64;
  localparam logic [1:0] OPBIT_RESET = 2'h0;
  localparam logic [1:0] OPBIT_RAISE = 2'h1;
  localparam logic [1:0] OPBIT_TSTC  = 2'h2;
  localparam logic [1:0] OPBIT_TSTS  = 2'h3;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_DEC, ALU_INC,
    ALU_PASSA, ALU_PASSW, ALU_ZERO, ALU_RL, ALU_RR, ALU_SWAP, ALU_BCLR, ALU_BSET
  } mde_alu_op_type;

  // host access to the file space
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mde_host_req_type;

  // flags produced by the alu
  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } mde_flags_type;

endpackage : mde_pkg

// >>> mde_alu.sv
// arithmetic and logic unit of the core
`timescale 1ns/1ps
module mde_alu
  import mde_pkg::*;
(
  input  mde_alu_op_type op,
  input  logic [7:0]     opa,
  input  logic [7:0]     wreg,
  input  logic           cin,
  input  logic [2:0]     bsel,
  output logic [7:0]     res,
  output mde_flags_type  flg
);

  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    res = opa;
    flg = '0;
    unique case (op)
      ALU_ADD: begin
        sum = {1'b0, opa} + {1'b0, wreg};
        nib = {1'b0, opa[3:0]} + {1'b0, wreg[3:0]};
        res = sum[7:0];
      end
      ALU_SUB: begin
        sum = {1'b0, opa} + {1'b0, ~wreg} + 9'h001;
        nib = {1'b0, opa[3:0]} + {1'b0, ~wreg[3:0]} + 5'h01;
        res = sum[7:0];
      end
      ALU_AND:   res = opa & wreg;
      ALU_IOR:   res = opa | wreg;
      ALU_XOR:   res = opa ^ wreg;
      ALU_COM:   res = ~opa;
      ALU_DEC:   res = opa - 8'h01;
      ALU_INC:   res = opa + 8'h01;
      ALU_PASSA: res = opa;
      ALU_PASSW: res = wreg;
      ALU_ZERO:  res = 8'h00;
      ALU_RL: begin
        res     = {opa[6:0], cin};
        sum[8]  = opa[7];
      end
      ALU_RR: begin
        res     = {cin, opa[7:1]};
        sum[8]  = opa[0];
      end
      ALU_SWAP:  res = {opa[3:0], opa[7:4]};
      ALU_BCLR:  res = opa & ~(8'h01 << bsel);
      ALU_BSET:  res = opa | (8'h01 << bsel);
    endcase
    flg.c  = sum[8];
    flg.dc = nib[4];
    flg.z  = (res == 8'h00);
  end

endmodule : mde_alu

// >>> mde_regfile.sv
// general file registers held in flip-flops
`timescale 1ns/1ps
module mde_regfile
  import mde_pkg::*;
#(
  parameter int unsigned DEPTH = 128
)
(
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic                we,
  input  wire logic [6:0]          waddr,
  input  wire logic [7:0]          wdata,
  input  wire logic [6:0]          raddr_a,
  output logic [7:0]               rdata_a,
  input  wire logic [6:0]          raddr_b,
  output logic [7:0]               rdata_b,
  output logic [PORT_NUM-1:0][7:0] port_latch
);

  if (DEPTH < 16 || DEPTH > 128) begin : g_bad_depth
    $error("mde_regfile: DEPTH must lie in 16..128");
  end

  logic [DEPTH-1:0][7:0] mem_q;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        mem_q[i] <= 8'h00;
      end else if (we && waddr == 7'(i)) begin
        mem_q[i] <= wdata;
      end
    end
  end

  for (genvar p = 0; p < PORT_NUM; p++) begin : g_port
    assign port_latch[p] = mem_q[ADDR_PORT0 + 7'(p)];
  end

  assign rdata_a = (32'(raddr_a) < DEPTH) ? mem_q[raddr_a] : 8'h00;
  assign rdata_b = (32'(raddr_b) < DEPTH) ? mem_q[raddr_b] : 8'h00;

endmodule : mde_regfile

// >>> mde_core.sv
// instruction decode and execute core
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
// Behaviour
// - one instruction cycle each; skips and branches add one idle cycle
// - an instruction cycle is four clock periods
// - flag updates win over bits written to the status register
// - pc low byte reads as itself; writing it loads upper pc from latch
// - bit clear and set rewrite the whole register
// - port registers read the pin levels, not the output latch
// - writing the timer clears the prescaler when assigned to it
// - rotates pass through carry and change only carry
// - register or, xor, and change only the zero flag
// - decrement/increment skip on zero, flags untouched
// - bit tests skip on clear or set, flags untouched
// - returns take two cycles; literal return loads accumulator
// - watchdog clear sets timeout and power down flags; standby sets timeout, clears power down
// - literal add and subtract set carry, nibble carry and zero
// - literal or and xor load accumulator, change only zero
// - destination bit picks accumulator or file register
// - file address field is seven bits, 0x00 to 0x7F
module mde_core
  import mde_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = 8,
  parameter int unsigned FILE_DEPTH  = 128
)
(
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  output logic [12:0]              prog_addr,
  input  wire logic [13:0]         prog_data,
  input  wire logic [PORT_NUM-1:0][7:0] port_pins,
  output logic [PORT_NUM-1:0][7:0] port_latch,
  input  wire logic                presc_on_timer,
  output logic                     presc_clear,
  output logic                     wdt_clear,
  output logic                     standby,
  output logic                     cycle_end,
  output logic [7:0]               acc_value,
  output logic [7:0]               status_value,
  input  wire mde_host_req_type    host_req,
  output logic [7:0]               host_rdata
);

  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_stack
    $error("mde_core: STACK_DEPTH must be a power of two, at least 2");
  end

  localparam int unsigned SPW = $clog2(STACK_DEPTH);

  mde_phase_type          phase_q;
  logic                   idle_q;
  logic [12:0]            pc_q;
  logic [4:0]             pc_high_holding_latch_q;
  logic [7:0]             w_q;
  logic [7:0]             status_q;
  logic [STACK_DEPTH-1:0][12:0] stack_q;
  logic [SPW-1:0]         sp_q;
  logic [7:0]             host_rdata_q;
  logic                   presc_clear_q;
  logic                   wdt_clear_q;
  logic                   standby_q;

  // ---------------------------------------------------------------
  // instruction fields
  // ---------------------------------------------------------------
  logic [13:0] ir;
  logic [1:0]  cls;
  logic [3:0]  sub;
  logic        dbit;
  logic [6:0]  faddr;
  logic [7:0]  k8;
  logic [10:0] k11;
  logic [2:0]  bsel;

  assign ir    = prog_data;
  assign cls   = ir[13:12];
  assign sub   = ir[11:8];
  assign dbit  = ir[7];
  assign faddr = ir[6:0];
  assign k8    = ir[7:0];
  assign k11   = ir[10:0];
  assign bsel  = ir[9:7];

  // ---------------------------------------------------------------
  // file read with special registers
  // ---------------------------------------------------------------
  logic [7:0] rf_rd_a;
  logic [7:0] rf_rd_b;
  logic [7:0] file_val;
  logic [7:0] host_val;

  function automatic logic [7:0] read_mux(input logic [6:0] a, input logic [7:0] rf);
    logic [7:0] v;
    v = rf;
    if (a == ADDR_PCL) v = pc_q[7:0];
    if (a == ADDR_STATUS) v = status_q;
    if (a == ADDR_PC_HIGH_HOLDING_LATCH) v = {3'h0, pc_high_holding_latch_q};
    for (int p = 0; p < PORT_NUM; p++) begin
      if (a == ADDR_PORT0 + 7'(p)) v = port_pins[p];
    end
    return v;
  endfunction : read_mux

  always_comb begin
    file_val = read_mux(faddr, rf_rd_a);
    host_val = read_mux(host_req.addr, rf_rd_b);
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [3:0]     alu_op;
  mde_alu_op_type alu_op_e;
  logic [7:0]     alu_a;
  logic [7:0]     alu_res;
  mde_flags_type  alu_flg;
  logic           to_w;
  logic           to_f;
  logic           upd_c;
  logic           upd_dc;
  logic           upd_z;
  logic           skip_zero;
  logic           skip_bit;
  logic           bit_want;
  logic           do_call;
  logic           do_jump;
  logic           do_ret;
  logic           do_stby;
  logic           do_wdclr;

  always_comb begin
    alu_op    = ALU_PASSA;
    alu_a     = file_val;
    to_w      = 1'b0;
    to_f      = 1'b0;
    upd_c     = 1'b0;
    upd_dc    = 1'b0;
    upd_z     = 1'b0;
    skip_zero = 1'b0;
    skip_bit  = 1'b0;
    bit_want  = 1'b0;
    do_call   = 1'b0;
    do_jump   = 1'b0;
    do_ret    = 1'b0;
    do_stby   = 1'b0;
    do_wdclr  = 1'b0;
    unique case (cls)
      CLS_BYTE: begin
        to_w = !dbit;
        to_f = dbit;
        unique case (sub)
          OPB_MOVWF: begin
            alu_op = ALU_PASSW;
            to_w   = 1'b0;
            if (!dbit) begin
              do_ret   = (k8 == CTL_RETURN) || (k8 == CTL_RETINT);
              do_stby  = (k8 == CTL_STBY);
              do_wdclr = (k8 == CTL_WDCLR);
            end
          end
          OPB_CLR: begin
            alu_op = ALU_ZERO;
            upd_z  = 1'b1;
          end
          OPB_SUB: begin
            alu_op = ALU_SUB;
            {upd_c, upd_dc, upd_z} = 3'b111;
          end
          OPB_ADD: begin
            alu_op = ALU_ADD;
            {upd_c, upd_dc, upd_z} = 3'b111;
          end
          OPB_IOR: {alu_op, upd_z} = {ALU_IOR, 1'b1};
          OPB_AND: {alu_op, upd_z} = {ALU_AND, 1'b1};
          OPB_XOR: {alu_op, upd_z} = {ALU_XOR, 1'b1};
          OPB_DEC: {alu_op, upd_z} = {ALU_DEC, 1'b1};
          OPB_INC: {alu_op, upd_z} = {ALU_INC, 1'b1};
          OPB_MOV: {alu_op, upd_z} = {ALU_PASSA, 1'b1};
          OPB_COM: {alu_op, upd_z} = {ALU_COM, 1'b1};
          OPB_DECSZ: {alu_op, skip_zero} = {ALU_DEC, 1'b1};
          OPB_INCSZ: {alu_op, skip_zero} = {ALU_INC, 1'b1};
          OPB_RR: {alu_op, upd_c} = {ALU_RR, 1'b1};
          OPB_RL: {alu_op, upd_c} = {ALU_RL, 1'b1};
          OPB_SWAP: alu_op = ALU_SWAP;
        endcase
      end
      CLS_BIT: begin
        unique case (sub[3:2])
          OPBIT_RESET: {alu_op, to_f} = {ALU_BCLR, 1'b1};
          OPBIT_RAISE: {alu_op, to_f} = {ALU_BSET, 1'b1};
          OPBIT_TSTC: {skip_bit, bit_want} = 2'b10;
          OPBIT_TSTS: {skip_bit, bit_want} = 2'b11;
        endcase
      end
      CLS_JUMP: begin
        do_call = !ir[11];
        do_jump = ir[11];
      end
      CLS_LIT: begin
        alu_a = k8;
        to_w  = 1'b1;
        unique casez (sub)
          4'b00??: alu_op = ALU_PASSA;
          4'b01??: {alu_op, do_ret} = {ALU_PASSA, 1'b1};
          4'b1000: {alu_op, upd_z} = {ALU_IOR, 1'b1};
          4'b1010: {alu_op, upd_z} = {ALU_XOR, 1'b1};
          4'b1001: {alu_op, upd_z} = {ALU_AND, 1'b1};
          4'b1011: to_w = 1'b0;
          4'b110?: begin
            alu_op = ALU_SUB;
            {upd_c, upd_dc, upd_z} = 3'b111;
          end
          4'b111?: begin
            alu_op = ALU_ADD;
            {upd_c, upd_dc, upd_z} = 3'b111;
          end
        endcase
      end
    endcase
  end

  assign alu_op_e = mde_alu_op_type'(alu_op);

  mde_alu u_alu (
    .op   (alu_op_e),
    .opa  (alu_a),
    .wreg (w_q),
    .cin  (status_q[ST_C]),
    .bsel (bsel),
    .res  (alu_res),
    .flg  (alu_flg)
  );

  // ---------------------------------------------------------------
  // commit control
  // ---------------------------------------------------------------
  logic        commit;
  logic        skip_take;
  logic        pcl_write;
  logic        core_we;
  logic        host_we;
  logic [12:0] pc_inc;

  assign commit    = (phase_q == MDE_PH4) && !idle_q;
  assign skip_take = (skip_zero && alu_flg.z) || (skip_bit && (file_val[bsel] == bit_want));
  assign pcl_write = to_f && (faddr == ADDR_PCL);
  assign core_we   = commit && to_f && (faddr != ADDR_STATUS) && (faddr != ADDR_PC_HIGH_HOLDING_LATCH)
                     && (faddr != ADDR_PCL);
  assign host_we   = host_req.wr && !core_we && (host_req.addr != ADDR_STATUS)
                     && (host_req.addr != ADDR_PC_HIGH_HOLDING_LATCH) && (host_req.addr != ADDR_PCL);
  assign pc_inc    = pc_q + 13'h0001;

  mde_regfile #(
    .DEPTH (FILE_DEPTH)
  ) u_regfile (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .we         (core_we || host_we),
    .waddr      (core_we ? faddr : host_req.addr),
    .wdata      (core_we ? alu_res : host_req.wdata),
    .raddr_a    (faddr),
    .rdata_a    (rf_rd_a),
    .raddr_b    (host_req.addr),
    .rdata_b    (rf_rd_b),
    .port_latch (port_latch)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // four periods per cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= MDE_PH1;
    end else begin
      unique case (phase_q)
        MDE_PH1: phase_q <= MDE_PH2;
        MDE_PH2: phase_q <= MDE_PH3;
        MDE_PH3: phase_q <= MDE_PH4;
        MDE_PH4: phase_q <= MDE_PH1;
        default: phase_q <= MDE_PH1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_q <= 1'b0;
    end else if (phase_q == MDE_PH4) begin
      idle_q <= commit && (skip_take || do_call || do_jump || do_ret || pcl_write);
    end
  end

  // ---------------------------------------------------------------
  // program counter and stack
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q <= PC_RST;
    end else if (commit) begin
      if (do_call || do_jump) begin
        pc_q <= {pc_high_holding_latch_q[4:3], k11};
      end else if (do_ret) begin
        pc_q <= stack_q[sp_q - SPW'(1)];
      end else if (pcl_write) begin
        pc_q <= {pc_high_holding_latch_q, alu_res};
      end else if (skip_take) begin
        // idle cycle holds the word after the skipped one
        pc_q <= pc_q + 13'h0002;
      end else begin
        pc_q <= pc_inc;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_q    <= '0;
      stack_q <= '0;
    end else if (commit && do_call) begin
      stack_q[sp_q] <= pc_inc;
      sp_q          <= sp_q + SPW'(1);
    end else if (commit && do_ret) begin
      sp_q <= sp_q - SPW'(1);
    end
  end

  // ---------------------------------------------------------------
  // accumulator, latch and status
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      w_q <= W_RST;
    end else if (commit && to_w) begin
      w_q <= alu_res;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_high_holding_latch_q <= PC_HIGH_HOLDING_LATCH_RST;
    end else if (commit && to_f && faddr == ADDR_PC_HIGH_HOLDING_LATCH) begin
      pc_high_holding_latch_q <= alu_res[4:0];
    end else if (host_req.wr && host_req.addr == ADDR_PC_HIGH_HOLDING_LATCH && !commit) begin
      pc_high_holding_latch_q <= host_req.wdata[4:0];
    end
  end

  logic [7:0] status_d;

  always_comb begin
    status_d = status_q;
    if (to_f && faddr == ADDR_STATUS) begin
      status_d = alu_res;
    end
    if (upd_c) status_d[ST_C] = alu_flg.c;
    if (upd_dc) status_d[ST_DC] = alu_flg.dc;
    if (upd_z) status_d[ST_Z] = alu_flg.z;
    if (do_wdclr) {status_d[ST_TO], status_d[ST_PD]} = 2'b11;
    if (do_stby) {status_d[ST_TO], status_d[ST_PD]} = 2'b10;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= STATUS_RST;
    end else if (commit) begin
      status_q <= status_d;
    end else if (host_req.wr && host_req.addr == ADDR_STATUS) begin
      status_q <= host_req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // side-effect pulses
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_clear_q <= 1'b0;
      wdt_clear_q   <= 1'b0;
      standby_q     <= 1'b0;
    end else begin
      presc_clear_q <= commit && to_f && (faddr == ADDR_TMR) && presc_on_timer;
      wdt_clear_q   <= commit && do_wdclr;
      standby_q     <= commit && do_stby;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata_q <= 8'h00;
    end else if (host_req.rd) begin
      host_rdata_q <= host_val;
    end
  end

  assign prog_addr    = pc_q;
  assign cycle_end    = (phase_q == MDE_PH4);
  assign acc_value    = w_q;
  assign status_value = status_q;
  assign presc_clear  = presc_clear_q;
  assign wdt_clear    = wdt_clear_q;
  assign standby      = standby_q;
  assign host_rdata   = host_rdata_q;

endmodule : mde_core

// >>> mde_core_assertions.sv
// port assertions for the decode/execute core
`timescale 1ns/1ps
module mde_core_assertions
  import mde_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = 8,
  parameter int unsigned FILE_DEPTH  = 128
)
(
  input wire logic                     ref_clk,
  input wire logic                     rst_b,
  input wire logic [12:0]              prog_addr,
  input wire logic [13:0]              prog_data,
  input wire logic [PORT_NUM-1:0][7:0] port_pins,
  input wire logic [PORT_NUM-1:0][7:0] port_latch,
  input wire logic                     presc_on_timer,
  input wire logic                     presc_clear,
  input wire logic                     wdt_clear,
  input wire logic                     standby,
  input wire logic                     cycle_end,
  input wire logic [7:0]               acc_value,
  input wire logic [7:0]               status_value,
  input wire mde_host_req_type         host_req,
  input wire logic [7:0]               host_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence idle_three;
    !cycle_end[*3];
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_cycle_period: assert property (cycle_end |=> idle_three ##1 cycle_end)
    else $error("instruction cycle is not four clocks");
  a_pc_commit: assert property (!$stable(prog_addr) |-> $past(cycle_end))
    else $error("program counter moved off a cycle end");
  a_wdt_flags: assert property (wdt_clear |-> $past(cycle_end) && status_value[ST_TO] && status_value[ST_PD])
    else $error("watchdog clear left wrong flags");
  a_stby_flags: assert property (standby |-> status_value[ST_TO] && !status_value[ST_PD])
    else $error("standby left wrong flags");
  a_stby_pulse: assert property (standby |=> !standby[*3])
    else $error("standby pulse too long");
  a_wdt_pulse: assert property (wdt_clear |=> !wdt_clear)
    else $error("watchdog clear pulse too long");
  a_presc_cause: assert property (presc_clear |-> $past(cycle_end) && $past(presc_on_timer))
    else $error("prescaler clear without cause");
  a_rdata_hold: assert property (!$past(host_req.rd) |-> $stable(host_rdata))
    else $error("read data moved without a read");
endmodule : mde_core_assertions

// >>> testbench.sv
// self-checking testbench for the decode/execute core
`timescale 1ns/1ps
module testbench;
  import mde_pkg::*;
  logic                     ref_clk        = 1'b0;
  logic                     rst_b          = 1'b0;
  logic [13:0]              prog_data      = 14'h0000;
  logic [PORT_NUM-1:0][7:0] port_pins      = '0;
  logic                     presc_on_timer = 1'b1;
  mde_host_req_type         host_req       = '0;
  logic [12:0]              prog_addr;
  logic [PORT_NUM-1:0][7:0] port_latch;
  logic                     presc_clear, wdt_clear, standby, cycle_end, rd_seen;
  logic [7:0]               acc_value, status_value, host_rdata;
  logic [7:0]               a, b, c, d, e, f, h, p, r, s1, s2, s3;
  logic [13:0]              mem [0:63];
  logic [7:0]               exp_q [$];
  int                       failures = 0;
  int                       checked  = 0;
  int                       n        = 0;
  int                       np, nw, ns;
  mde_core i_mde_core (.*);
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) prog_data <= mem[prog_addr[5:0]];
  // ---------------------------------------------------------------
  // monitor
  // ---------------------------------------------------------------
  always @(negedge ref_clk) begin
    np += presc_clear;
    nw += wdt_clear;
    ns += standby;
    if (rd_seen === 1'b1) begin
      checked++;
      if (host_rdata !== exp_q[0]) begin
        failures++;
        $display("BAD %0t read %h want %h", $time, host_rdata, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
    rd_seen = host_req.rd;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] sw(input logic [7:0] x);
    return {x[3:0], x[7:4]};
  endfunction : sw
  task automatic put(input logic [13:0] w);
    mem[n] = w;
    n++;
  endtask : put
  task automatic rd(input logic [6:0] ad, input logic [7:0] ex);
    exp_q.push_back(ex);
    host_req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
  endtask : rd
  task automatic chk(input logic [12:0] got, input logic [12:0] ex);
    checked++;
    if (got !== ex) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, ex);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3000) @(posedge ref_clk);
    failures++;
    give_verdict();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(97));
    {a, b, c, d} = $urandom;
    {e, f, h, p} = $urandom;
    r = $urandom;
    port_pins[0] = p;
    foreach (mem[i]) mem[i] = 14'h0000;
    put(14'h3000 | a); put(14'h3E00 | b); put(14'h00A0); put(14'h0E03); put(14'h00A1);
    put(14'h3000 | c); put(14'h3C00 | d); put(14'h00A2); put(14'h0E03); put(14'h00A3);
    put(14'h0183); put(14'h0E03); put(14'h00A4); put(14'h0064); put(14'h0E03);
    put(14'h00A5); put(14'h3000 | e); put(14'h00A6); put(14'h11A6); put(14'h1726);
    put(14'h3000 | e); put(14'h00A7); put(14'h0DA7); put(14'h0C27); put(14'h00A8);
    put(14'h3001); put(14'h00A9); put(14'h0BA9); put(14'h3055); put(14'h1829);
    put(14'h3066); put(14'h00AA); put(14'h203C); put(14'h3A00 | h); put(14'h00AB);
    put(14'h30FF); put(14'h0085); put(14'h0E85); put(14'h0081); put(14'h0063);
    put(14'h0E03); put(14'h00AC); put(14'h203D); put(14'h0802); put(14'h00AD);
    put(14'h3031); put(14'h0082); put(14'h3077); put(14'h3077); put(14'h00AE);
    put(14'h00AF); put(14'h3800 | a); put(14'h06AF); put(14'h2800 | 14'(n));
    mem[60] = 14'h3400 | f;
    mem[61] = 14'h0008;
    s1 = {5'b00011, a + b == 8'h00, {1'b0, a[3:0]} + b[3:0] > 5'h0F, {1'b0, a} + b > 9'h0FF};
    s2 = {5'b00011, d == c, d[3:0] >= c[3:0], d >= c};
    s3 = {5'b00010, (f ^ h) == 8'h00, 2'b00};
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (400) @(posedge ref_clk);
    rd(7'h20, a + b);
    rd(7'h21, sw(s1));
    rd(7'h22, d - c);
    rd(7'h23, sw(s2));
    rd(7'h24, 8'h40);
    rd(7'h25, 8'hC1);
    rd(7'h26, (e & 8'hF7) | 8'h40);
    rd(7'h27, {e[6:0], 1'b0});
    rd(7'h28, e);
    rd(7'h29, 8'h00);
    rd(7'h2A, 8'h01);
    rd(7'h2B, f ^ h);
    rd(7'h2C, sw(s3));
    rd(7'h2D, 8'h2B);
    rd(7'h2E, 8'h31);
    rd(7'h2F, (a | 8'h31) ^ 8'h31);
    rd(7'h05, p);
    host_req <= '{addr: 7'h30, wdata: r, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    rd(7'h30, r);
    host_req <= '0;
    repeat (4) @(posedge ref_clk);
    checked++;
    // port rewrite from pins
    if (port_latch[0] !== sw(p)) begin
      failures++;
      $display("BAD %0t port latch %h", $time, port_latch[0]);
    end
    chk(13'(acc_value), 13'(a | 8'h31));
    chk(prog_addr, 13'h0035);
    chk(13'(np), 13'h0001);
    chk(13'(nw + ns), 13'h0002);
    give_verdict();
  end
endmodule : testbench
bind mde_core mde_core_assertions #(
  .STACK_DEPTH(STACK_DEPTH),
  .FILE_DEPTH(FILE_DEPTH)
) i_mde_core_assertions (.*);
